// ### design/uie_irq_enable_bank.sv
// Interrupt enable bank of an asynchronous serial port, with the receive
// data available and character time-out conditions and an interrupt
// status/mask pair feeding one level interrupt.
// Assumes a 10 MHz clock, synchronous inputs, and a register port whose
// read data appear one cycle after the read strobe.
//
// Operation
// - Enable register decoded only with latch-access clear
// - Bit 0 gates data-available and time-out
// - Bit 1 gates transmit-holding-empty interrupt
// - Bit 2 gates receive line status interrupts
// - Bit 8 gates auto-baud time-out interrupt
// - Bit 9 gates auto-baud done interrupt
// - Reserved bits written zero, read back zero
// - Data available at trigger level, drops below
// - Time-out after 3.5-4.5 idle character times
`timescale 1ns/1ns
`default_nettype none
module uie_irq_enable_bank #(
    parameter int FIFO_CNT_W = 5,
    parameter int BAUD_DIV   = uie_pkg::BAUD_DIV_DEFAULT,
    parameter int CHAR_BITS  = uie_pkg::CHAR_BITS
) (
    // Clock and reset
    input  wire logic                  CLK_SYS,
    input  wire logic                  SYS_RST,
    // Register port
    input  wire logic [31:0]           REG_ADDR,
    input  wire logic [31:0]           REG_WDATA,
    input  wire logic                  REG_WR,
    input  wire logic                  REG_RD,
    output logic [31:0]                REG_RDATA,
    // Divisor latch access bit from the line control register
    input  wire logic                  DIVISOR_LATCH_ACCESS,
    // Receive FIFO state
    input  wire logic [FIFO_CNT_W-1:0] RX_FIFO_FILL,
    input  wire logic [1:0]            FIFO_CTRL_TRIG,
    input  wire logic                  RX_FIFO_ACTIVITY,
    // Other pending source conditions
    input  wire uie_pkg::uie_src_t     SRC_PENDING,
    // Gated source requests and interrupt
    output logic                       RX_DATA_AVAILABLE,
    output logic                       CHAR_TIMEOUT_INDICATOR,
    output logic [4:0]                 IRQ_REQ,
    output logic                       IRQ
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Trigger level from the FIFO control field: 1, 4, 8 or 14 characters
    function automatic logic [FIFO_CNT_W-1:0] trig_level(input logic [1:0] sel);
        logic [FIFO_CNT_W-1:0] lvl;
        lvl = '0;
        unique case (sel)
            2'h0: lvl = FIFO_CNT_W'(1);
            2'h1: lvl = FIFO_CNT_W'(4);
            2'h2: lvl = FIFO_CNT_W'(8);
            2'h3: lvl = FIFO_CNT_W'(14);
        endcase
        return lvl;
    endfunction : trig_level

    function automatic logic addr_is(input logic [31:0] a, input logic [31:0] ref_a);
        return a == ref_a;
    endfunction : addr_is

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    uie_pkg::uie_bus_req_t req;
    assign req.wr    = REG_WR;
    assign req.rd    = REG_RD;
    assign req.addr  = REG_ADDR;
    assign req.wdata = REG_WDATA;

    // With the latch-access bit set the shared address belongs to the divisor
    wire sel_enable = addr_is(req.addr, uie_pkg::IRQ_SOURCE_ENABLE_ADDR)
                      && !DIVISOR_LATCH_ACCESS;
    wire sel_status = addr_is(req.addr, uie_pkg::IRQ_STATUS_ADDR);
    wire sel_mask   = addr_is(req.addr, uie_pkg::IRQ_MASK_ADDR);
    wire sel_tstate = addr_is(req.addr, uie_pkg::TIMEOUT_STATE_ADDR);

    wire wr_enable = req.wr && sel_enable;
    wire wr_status = req.wr && sel_status;
    wire wr_mask   = req.wr && sel_mask;

    // ------------------------------------------------------------------
    // Enable register
    // ------------------------------------------------------------------
    logic [31:0] enable_r;
    logic [31:0] enable_nxt;

    // Reserved positions are not stored; they read back as zero
    assign enable_nxt = wr_enable ? (req.wdata & uie_pkg::ENABLE_WMASK) : enable_r;

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            enable_r <= uie_pkg::IRQ_SOURCE_ENABLE_RST;
        end else begin
            enable_r <= enable_nxt;
        end
    end

    wire en_rx_data  = enable_r[uie_pkg::EN_RX_DATA_BIT];
    wire en_tx_empty = enable_r[uie_pkg::EN_TX_EMPTY_BIT];
    wire en_line     = enable_r[uie_pkg::EN_LINE_STAT_BIT];
    wire en_ab_to    = enable_r[uie_pkg::EN_AB_TIMEOUT_BIT];
    wire en_ab_done  = enable_r[uie_pkg::EN_AB_DONE_BIT];

    // ------------------------------------------------------------------
    // Receive conditions
    // ------------------------------------------------------------------
    logic        rxd_avail_r;
    logic [15:0] baud_cnt_r;
    logic [15:0] baud_cnt_nxt;
    logic        char_tick_r;
    logic        timeout_hit;
    uie_pkg::uie_to_state_t to_state;

    // Level condition: follows the fill both up and down
    wire rxd_avail_cond = (RX_FIFO_FILL >= trig_level(FIFO_CTRL_TRIG));

    // One character time is CHAR_BITS baud periods of BAUD_DIV clocks
    localparam logic [15:0] CHAR_CLKS = 16'(BAUD_DIV * CHAR_BITS);
    wire baud_wrap = (baud_cnt_r == CHAR_CLKS - 16'h0001);
    // Half-character ticks give the time-out its finer resolution
    wire half_wrap = baud_wrap || (baud_cnt_r == CHAR_CLKS / 16'h0002 - 16'h0001);
    assign baud_cnt_nxt = baud_wrap ? 16'h0000 : baud_cnt_r + 16'h0001;

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            rxd_avail_r <= 1'b0;
            baud_cnt_r  <= 16'h0000;
            char_tick_r <= 1'b0;
        end else begin
            rxd_avail_r <= rxd_avail_cond;
            baud_cnt_r  <= baud_cnt_nxt;
            char_tick_r <= half_wrap;
        end
    end

    uie_char_timer #(
        .CNT_W (3)
    ) u_char_timer (
        .clk           (CLK_SYS),
        .rst           (SYS_RST),
        .char_tick     (char_tick_r),
        .fifo_activity (RX_FIFO_ACTIVITY),
        .fifo_nonempty (RX_FIFO_FILL != '0),
        .timeout       (timeout_hit),
        .state         (to_state)
    );

    // ------------------------------------------------------------------
    // Gated requests
    // ------------------------------------------------------------------
    // Clearing an enable hides a source but leaves its condition intact
    logic [4:0] pend;
    assign pend[uie_pkg::EV_RX_DATA]    = rxd_avail_r || timeout_hit;
    assign pend[uie_pkg::EV_TX_EMPTY]   = SRC_PENDING.tx_empty;
    assign pend[uie_pkg::EV_LINE_STAT]  = SRC_PENDING.line_status;
    assign pend[uie_pkg::EV_AB_TIMEOUT] = SRC_PENDING.ab_timeout;
    assign pend[uie_pkg::EV_AB_DONE]    = SRC_PENDING.ab_done;

    logic [4:0] gate;
    assign gate[uie_pkg::EV_RX_DATA]    = en_rx_data;
    assign gate[uie_pkg::EV_TX_EMPTY]   = en_tx_empty;
    assign gate[uie_pkg::EV_LINE_STAT]  = en_line;
    assign gate[uie_pkg::EV_AB_TIMEOUT] = en_ab_to;
    assign gate[uie_pkg::EV_AB_DONE]    = en_ab_done;

    wire [4:0] req_nxt = pend & gate;

    logic [4:0] irq_req_r;
    logic       rxd_out_r;
    logic       tmo_out_r;

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            irq_req_r <= 5'h00;
            rxd_out_r <= 1'b0;
            tmo_out_r <= 1'b0;
        end else begin
            irq_req_r <= req_nxt;
            rxd_out_r <= rxd_avail_r && en_rx_data;
            tmo_out_r <= timeout_hit && en_rx_data;
        end
    end

    assign IRQ_REQ                = irq_req_r;
    assign RX_DATA_AVAILABLE      = rxd_out_r;
    assign CHAR_TIMEOUT_INDICATOR = tmo_out_r;

    // ------------------------------------------------------------------
    // Sticky status and mask
    // ------------------------------------------------------------------
    logic [4:0] status_r;
    logic [4:0] status_nxt;
    logic [4:0] mask_r;
    logic [4:0] req_prev_r;

    // Rising edge of a gated request is the event; set wins over clear
    wire [4:0] ev_set = irq_req_r & ~req_prev_r;
    wire [4:0] clr    = wr_status ? req.wdata[4:0] : 5'h00;
    assign status_nxt = (status_r & ~clr) | ev_set;

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            status_r   <= uie_pkg::IRQ_STATUS_RST;
            mask_r     <= uie_pkg::IRQ_MASK_RST;
            req_prev_r <= 5'h00;
        end else begin
            status_r   <= status_nxt;
            req_prev_r <= irq_req_r;
            if (wr_mask) begin
                mask_r <= req.wdata[4:0];
            end
        end
    end

    assign IRQ = |(status_r & mask_r);

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = uie_pkg::UNMAPPED_READ;
        if (sel_enable) begin
            rd_mux = enable_r;
        end else if (sel_status) begin
            rd_mux = {27'h0, status_r};
        end else if (sel_mask) begin
            rd_mux = {27'h0, mask_r};
        end else if (sel_tstate) begin
            rd_mux = {24'h0, 2'h0, 1'b0, timeout_hit, rxd_avail_r, 1'b0, to_state};
        end
    end

    logic [31:0] rdata_r;
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            rdata_r <= 32'h00000000;
        end else if (req.rd) begin
            rdata_r <= rd_mux;
        end else begin
            rdata_r <= 32'h00000000;
        end
    end

    assign REG_RDATA = rdata_r;

endmodule : uie_irq_enable_bank
`default_nettype wire

// ### design/uie_pkg.sv
// Package for the serial port interrupt enable bank: offsets, fields,
// reset values and timing figures.
// Assumes a 10 MHz system clock and a plain word-wide register port.
package uie_pkg;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [31:0] IRQ_SOURCE_ENABLE_ADDR = 32'he000c004;
    localparam logic [31:0] IRQ_STATUS_ADDR        = 32'he000c040;
    localparam logic [31:0] IRQ_MASK_ADDR          = 32'he000c044;
    localparam logic [31:0] TIMEOUT_STATE_ADDR     = 32'he000c048;

    // ----------------------------------------------------------------
    // Enable field positions and reset values
    // ----------------------------------------------------------------
    localparam int EN_RX_DATA_BIT    = 0;
    localparam int EN_TX_EMPTY_BIT   = 1;
    localparam int EN_LINE_STAT_BIT  = 2;
    localparam int EN_AB_TIMEOUT_BIT = 8;
    localparam int EN_AB_DONE_BIT    = 9;
    localparam logic [31:0] IRQ_SOURCE_ENABLE_RST = 32'h00000000;
    localparam logic [31:0] ENABLE_WMASK          = 32'h00000307;
    localparam logic [4:0]  IRQ_STATUS_RST        = 5'h00;
    localparam logic [4:0]  IRQ_MASK_RST          = 5'h00;
    localparam logic [31:0] UNMAPPED_READ         = 32'h00000000;

    // Event bits of the status and mask registers
    localparam int EV_RX_DATA    = 0;
    localparam int EV_TX_EMPTY   = 1;
    localparam int EV_LINE_STAT  = 2;
    localparam int EV_AB_TIMEOUT = 3;
    localparam int EV_AB_DONE    = 4;
    localparam int NUM_EVENTS    = 5;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS       = 100;
    localparam int CHAR_BITS           = 10;
    localparam int BAUD_DIV_DEFAULT    = 65;
    // Time-out window in tenths of a character: 3.5 to 4.5 characters
    localparam int TIMEOUT_MIN_TENTHS  = 35;
    localparam int TIMEOUT_MAX_TENTHS  = 45;
    // Character clocks counted: 4, inside the 3.5 to 4.5 window
    localparam int TIMEOUT_CHARS       = (TIMEOUT_MIN_TENTHS + 9) / 10;
    localparam logic [1:0] TRIG_LEVEL_RST = 2'h0;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [31:0] addr;
        logic [31:0] wdata;
    } uie_bus_req_t;

    typedef struct packed {
        logic line_status;
        logic tx_empty;
        logic ab_timeout;
        logic ab_done;
    } uie_src_t;

    typedef enum logic [1:0] {
        TO_IDLE  = 2'b00,
        TO_COUNT = 2'b01,
        TO_FIRED = 2'b10
    } uie_to_state_t;

endpackage : uie_pkg

// ### design/uie_char_timer.sv
// Character time-out detector for the receive FIFO.
// Assumes a one-cycle half-character pulse from the baud divider and a
// one-cycle activity pulse on every FIFO read or write.
`timescale 1ns/1ns
`default_nettype none
module uie_char_timer #(
    parameter int CNT_W = 3
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // Character tick and FIFO state
    input  wire logic                    char_tick,
    input  wire logic                    fifo_activity,
    input  wire logic                    fifo_nonempty,
    // Result
    output logic                         timeout,
    output uie_pkg::uie_to_state_t       state
);

    uie_pkg::uie_to_state_t state_r;
    uie_pkg::uie_to_state_t state_nxt;
    logic [CNT_W-1:0]       cnt_r;
    logic [CNT_W-1:0]       cnt_nxt;

    // Ticks come every half character, so counting twice the character limit
    // fires 3.5 to 4 characters after the last activity; whole-character
    // ticks would let it fire after barely three.
    wire limit_hit = (cnt_r == CNT_W'(2 * uie_pkg::TIMEOUT_CHARS - 1)) && char_tick;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        unique case (state_r)
            uie_pkg::TO_IDLE: begin
                cnt_nxt = '0;
                if (fifo_nonempty && !fifo_activity) begin
                    state_nxt = uie_pkg::TO_COUNT;
                end
            end
            uie_pkg::TO_COUNT: begin
                if (fifo_activity || !fifo_nonempty) begin
                    state_nxt = uie_pkg::TO_IDLE;
                    cnt_nxt   = '0;
                end else if (limit_hit) begin
                    state_nxt = uie_pkg::TO_FIRED;
                end else if (char_tick) begin
                    cnt_nxt = cnt_r + CNT_W'(1);
                end
            end
            uie_pkg::TO_FIRED: begin
                // Any FIFO activity clears the indication
                if (fifo_activity || !fifo_nonempty) begin
                    state_nxt = uie_pkg::TO_IDLE;
                end
            end
            default: begin
                state_nxt = uie_pkg::TO_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= uie_pkg::TO_IDLE;
            cnt_r   <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    assign timeout = (state_r == uie_pkg::TO_FIRED);
    assign state   = state_r;

endmodule : uie_char_timer
`default_nettype wire

// ### bench/uie_bank_properties.sv
// Port-level properties of the interrupt enable bank.
// Assumes binding to uie_irq_enable_bank; shadows enable, status and mask.
`timescale 1ns/1ns
`default_nettype none
module uie_bank_properties #(
    parameter int FIFO_CNT_W = 5
) (
    // Clock and reset
    input wire logic                  CLK_SYS,
    input wire logic                  SYS_RST,
    // Register port
    input wire logic [31:0]           REG_ADDR,
    input wire logic [31:0]           REG_WDATA,
    input wire logic                  REG_WR,
    input wire logic                  REG_RD,
    input wire logic [31:0]           REG_RDATA,
    input wire logic                  DIVISOR_LATCH_ACCESS,
    // Sources and requests
    input wire logic [FIFO_CNT_W-1:0] RX_FIFO_FILL,
    input wire logic [1:0]            FIFO_CTRL_TRIG,
    input wire logic                  RX_FIFO_ACTIVITY,
    input wire uie_pkg::uie_src_t     SRC_PENDING,
    input wire logic                  RX_DATA_AVAILABLE,
    input wire logic                  CHAR_TIMEOUT_INDICATOR,
    input wire logic [4:0]            IRQ_REQ,
    input wire logic                  IRQ
);
    // ------------------------------------------------------------
    // Shadow registers
    // ------------------------------------------------------------
    logic [31:0] en_r;
    logic [4:0]  st_r;
    logic [4:0]  mk_r;
    logic [4:0]  req_r;
    wire  en_hit = REG_ADDR == uie_pkg::IRQ_SOURCE_ENABLE_ADDR;
    wire  wr_en  = REG_WR && en_hit && !DIVISOR_LATCH_ACCESS;
    wire  rd_en  = REG_RD && en_hit && !DIVISOR_LATCH_ACCESS;
    wire  rd_dla = REG_RD && en_hit && DIVISOR_LATCH_ACCESS;
    wire  wr_st  = REG_WR && REG_ADDR == uie_pkg::IRQ_STATUS_ADDR;
    wire  wr_mk  = REG_WR && REG_ADDR == uie_pkg::IRQ_MASK_ADDR;
    wire [4:0] trig_lvl = FIFO_CTRL_TRIG == 2'h0 ? 5'h01 : FIFO_CTRL_TRIG == 2'h1 ? 5'h04 :
                          FIFO_CTRL_TRIG == 2'h2 ? 5'h08 : 5'h0e;
    wire  at_lvl = 32'(RX_FIFO_FILL) >= 32'(trig_lvl);
    // Set wins over a clear in the same cycle
    wire [4:0] st_nxt = (st_r & ~(wr_st ? REG_WDATA[4:0] : 5'h00)) | (IRQ_REQ & ~req_r);

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            en_r  <= 32'h0;
            st_r  <= 5'h00;
            mk_r  <= 5'h00;
            req_r <= 5'h00;
        end else begin
            en_r  <= wr_en ? (REG_WDATA & uie_pkg::ENABLE_WMASK) : en_r;
            mk_r  <= wr_mk ? REG_WDATA[4:0] : mk_r;
            st_r  <= st_nxt;
            req_r <= IRQ_REQ;
        end
    end

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (SYS_RST);

    a_rdata_enable: assert property ($past(rd_en) |-> REG_RDATA == $past(en_r))
        else $error("enable readback wrong");
    a_rdata_latch: assert property ($past(rd_dla) |-> REG_RDATA == 32'h0)
        else $error("enable visible while latch access set");
    a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
        else $error("read data outside its cycle");
    a_req_tx_gate: assert property (IRQ_REQ[1] == $past(SRC_PENDING.tx_empty & en_r[1]))
        else $error("tx empty request gating wrong");
    a_req_line_gate: assert property (IRQ_REQ[2] == $past(SRC_PENDING.line_status & en_r[2]))
        else $error("line status request gating wrong");
    a_req_abto_gate: assert property (IRQ_REQ[3] == $past(SRC_PENDING.ab_timeout & en_r[8]))
        else $error("auto-baud time-out gating wrong");
    a_req_abdone_gate: assert property (IRQ_REQ[4] == $past(SRC_PENDING.ab_done & en_r[9]))
        else $error("auto-baud done gating wrong");
    a_rx_gate_off: assert property (!en_r[0] |=> !IRQ_REQ[0] && !RX_DATA_AVAILABLE)
        else $error("receive request with enable clear");
    a_rda_at_level: assert property (at_lvl ##1 en_r[0] |=> IRQ_REQ[0])
        else $error("data available missing at level");
    a_irq_level: assert property (IRQ == |(st_r & mk_r))
        else $error("interrupt level wrong");

    c_irq_raised: cover property ($rose(IRQ));
    c_timeout_fired: cover property ($rose(CHAR_TIMEOUT_INDICATOR));
    c_latch_read: cover property (rd_dla);
endmodule : uie_bank_properties
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench for the interrupt enable bank.
// Assumes a 10 MHz clock and the design built with BAUD_DIV of 1.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam logic [31:0] EN_A = uie_pkg::IRQ_SOURCE_ENABLE_ADDR;
    localparam logic [31:0] ST_A = uie_pkg::IRQ_STATUS_ADDR;
    localparam logic [31:0] MK_A = uie_pkg::IRQ_MASK_ADDR;
    typedef struct {logic [31:0] wd; logic [3:0] src; logic [3:0] req;} uie_row_t;
    // Source order is {line, tx, abto, abdone}; request order is [4:1] = {abdone, abto, line, tx}
    uie_row_t rows [7] = '{'{32'h307, 4'hf, 4'hf}, '{32'h002, 4'hf, 4'h1}, '{32'h004, 4'h8, 4'h2},
        '{32'h100, 4'h2, 4'h4}, '{32'h200, 4'h1, 4'h8}, '{32'h306, 4'h4, 4'h1},
        '{32'h000, 4'hf, 4'h0}};
    logic [4:0]  lvls [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
    logic CLK_SYS, SYS_RST, REG_WR, REG_RD, DIVISOR_LATCH_ACCESS, RX_FIFO_ACTIVITY;
    logic [31:0] REG_ADDR, REG_WDATA, REG_RDATA;
    logic [4:0]  RX_FIFO_FILL, IRQ_REQ;
    logic [1:0]  FIFO_CTRL_TRIG;
    logic        RX_DATA_AVAILABLE, CHAR_TIMEOUT_INDICATOR, IRQ;
    uie_pkg::uie_src_t SRC_PENDING;
    int bad_count, comparisons, cycles;

    uie_irq_enable_bank #(.FIFO_CNT_W(5), .BAUD_DIV(1)) i_dut (.CLK_SYS(CLK_SYS),
        .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
        .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .DIVISOR_LATCH_ACCESS(DIVISOR_LATCH_ACCESS),
        .RX_FIFO_FILL(RX_FIFO_FILL), .FIFO_CTRL_TRIG(FIFO_CTRL_TRIG),
        .RX_FIFO_ACTIVITY(RX_FIFO_ACTIVITY), .SRC_PENDING(SRC_PENDING),
        .RX_DATA_AVAILABLE(RX_DATA_AVAILABLE), .CHAR_TIMEOUT_INDICATOR(CHAR_TIMEOUT_INDICATOR),
        .IRQ_REQ(IRQ_REQ), .IRQ(IRQ));

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge CLK_SYS);
        REG_WR    <= 1'b1;
        REG_ADDR  <= a;
        REG_WDATA <= d;
        @(posedge CLK_SYS);
        REG_WR    <= 1'b0;
    endtask : wr

    // Read data are valid only in the cycle after the strobe
    task automatic rdc(input string what, input logic [31:0] a, input logic [31:0] exp);
        @(posedge CLK_SYS);
        REG_RD   <= 1'b1;
        REG_ADDR <= a;
        @(posedge CLK_SYS);
        REG_RD   <= 1'b0;
        @(negedge CLK_SYS);
        chk(what, REG_RDATA, exp);
    endtask : rdc

    task automatic look(input int n);
        repeat (n) @(posedge CLK_SYS);
        @(negedge CLK_SYS);
    endtask : look

    // Every fill change comes with an activity pulse, as a FIFO write or read would
    task automatic fifo(input logic [1:0] tr, input logic [4:0] f);
        @(posedge CLK_SYS);
        FIFO_CTRL_TRIG   <= tr;
        RX_FIFO_FILL     <= f;
        RX_FIFO_ACTIVITY <= 1'b1;
        @(posedge CLK_SYS);
        RX_FIFO_ACTIVITY <= 1'b0;
    endtask : fifo

    initial begin
        CLK_SYS = 1'b0;
        forever #50 CLK_SYS = ~CLK_SYS;
    end

    // Hang guard, well above the few hundred cycles the tests take
    always @(posedge CLK_SYS) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            $display("[ERR] run length expected below 5000 seen 5000");
            end_of_test();
        end
    end

    initial begin
        {SYS_RST, REG_WR, REG_RD, DIVISOR_LATCH_ACCESS, RX_FIFO_ACTIVITY} = 5'h10;
        {REG_ADDR, REG_WDATA, RX_FIFO_FILL, FIFO_CTRL_TRIG} = '0;
        SRC_PENDING = '0;
        repeat (3) @(posedge CLK_SYS);
        SYS_RST <= 1'b0;
        rdc("enable reset", EN_A, 32'h0);
        rdc("status reset", ST_A, 32'h0);
        rdc("mask reset", MK_A, 32'h0);
        $display("reset values done");
        foreach (rows[i]) begin
            wr(EN_A, rows[i].wd);
            SRC_PENDING <= rows[i].src;
            look(2);
            chk("gated requests", {28'h0, IRQ_REQ[4:1]}, {28'h0, rows[i].req});
            rdc("enable readback", EN_A, rows[i].wd);
        end
        $display("gating table done");
        @(posedge CLK_SYS);
        DIVISOR_LATCH_ACCESS <= 1'b1;
        wr(EN_A, 32'h307);
        rdc("enable hidden", EN_A, 32'h0);
        @(posedge CLK_SYS);
        DIVISOR_LATCH_ACCESS <= 1'b0;
        rdc("enable unchanged", EN_A, 32'h0);
        rdc("unmapped read", 32'he000c0fc, 32'h0);
        $display("latch access done");
        wr(EN_A, 32'h1);
        for (int t = 0; t < 4; t++) begin
            fifo(2'(t), lvls[t] - 5'h01);
            look(3);
            chk("below level", {31'h0, RX_DATA_AVAILABLE}, 32'h0);
            fifo(2'(t), lvls[t]);
            look(3);
            chk("at level", {30'h0, RX_DATA_AVAILABLE, IRQ_REQ[0]}, 32'h3);
        end
        wr(EN_A, 32'h0);
        look(2);
        chk("rx masked", {30'h0, RX_DATA_AVAILABLE, IRQ_REQ[0]}, 32'h0);
        wr(EN_A, 32'h1);
        look(2);
        chk("rx unmasked", {31'h0, IRQ_REQ[0]}, 32'h1);
        $display("trigger levels done");
        fifo(2'h3, 5'h01);
        look(35);
        chk("no early timeout", {31'h0, CHAR_TIMEOUT_INDICATOR}, 32'h0);
        look(15);
        chk("timeout fired", {30'h0, CHAR_TIMEOUT_INDICATOR, IRQ_REQ[0]}, 32'h3);
        rdc("timeout state", uie_pkg::TIMEOUT_STATE_ADDR, 32'h12);
        fifo(2'h3, 5'h01);
        look(3);
        chk("timeout cleared", {31'h0, CHAR_TIMEOUT_INDICATOR}, 32'h0);
        fifo(2'h3, 5'h00);
        $display("character timeout done");
        @(posedge CLK_SYS);
        SRC_PENDING <= '0;
        wr(ST_A, 32'h1f);
        rdc("status cleared", ST_A, 32'h0);
        wr(EN_A, 32'h2);
        wr(MK_A, 32'h2);
        @(posedge CLK_SYS);
        SRC_PENDING <= 4'h4;
        look(3);
        chk("irq raised", {31'h0, IRQ}, 32'h1);
        rdc("status tx", ST_A, 32'h2);
        wr(MK_A, 32'h0);
        look(1);
        chk("irq masked", {31'h0, IRQ}, 32'h0);
        rdc("status kept", ST_A, 32'h2);
        wr(MK_A, 32'h2);
        wr(ST_A, 32'h2);
        look(1);
        chk("irq cleared", {31'h0, IRQ}, 32'h0);
        $display("interrupt path done");
        @(posedge CLK_SYS);
        SYS_RST <= 1'b1;
        @(posedge CLK_SYS);
        SYS_RST <= 1'b0;
        rdc("enable after reset", EN_A, 32'h0);
        chk("requests after reset", {27'h0, IRQ_REQ}, 32'h0);
        $display("second reset done");
        end_of_test();
    end
endmodule : tb_top

bind uie_irq_enable_bank uie_bank_properties #(.FIFO_CNT_W(FIFO_CNT_W)) i_props (
    .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .DIVISOR_LATCH_ACCESS(DIVISOR_LATCH_ACCESS), .RX_FIFO_FILL(RX_FIFO_FILL),
    .FIFO_CTRL_TRIG(FIFO_CTRL_TRIG), .RX_FIFO_ACTIVITY(RX_FIFO_ACTIVITY),
    .SRC_PENDING(SRC_PENDING), .RX_DATA_AVAILABLE(RX_DATA_AVAILABLE),
    .CHAR_TIMEOUT_INDICATOR(CHAR_TIMEOUT_INDICATOR), .IRQ_REQ(IRQ_REQ), .IRQ(IRQ));
`default_nettype wire
